// *** logic/kih_pkg.sv ***
// Package: constants and types for the keypad indicator and key handler
package kih_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int BLINK_HALF_MS = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
    localparam int BLINK_W = 27;

    // ------------------------------------------------------------
    // Register map (word offsets are byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_MENU = 8'h10;
    localparam logic [7:0] ADDR_DISPLAY = 8'h14;

    // CTRL fields
    localparam int CTRL_SHORTCUT_LSB = 0;
    localparam int CTRL_STOPSCOPE_BIT = 4;
    localparam int CTRL_DEFAULTS_BIT = 8;
    localparam logic [2:0] SHORTCUT_RESET = 3'h1;
    localparam logic STOPSCOPE_RESET = 1'b0;

    // Display geometry
    localparam logic [7:0] DISP_COLS = 8'hF0;
    localparam logic [7:0] DISP_ROWS = 8'hA0;
    localparam logic [2:0] MONITOR_ITEMS = 3'h3;
    localparam logic [2:0] SUBMENU_ITEMS = 3'h6;

    // Interrupt event bits
    localparam int EV_RUN = 0;
    localparam int EV_STOP = 1;
    localparam int EV_FAULT_RST = 2;
    localparam int EV_SHORTCUT = 3;
    localparam int EV_NAV = 4;
    localparam int EV_FUNC = 5;
    localparam int EV_W = 6;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SC_NONE,
        SC_JOG,
        SC_RSVD2,
        SC_DIR_TOGGLE,
        SC_CLEAR_UPDN,
        SC_COAST,
        SC_CMD_STEP,
        SC_RSVD7
    } kih_shortcut_t;

    typedef enum logic [1:0] {
        CMD_KEYPAD,
        CMD_TERMINAL,
        CMD_COMM
    } kih_cmd_src_t;

    typedef struct packed {
        logic running;
        logic autotune;
        logic fault;
        logic pre_alarm;
        logic [1:0] cmd_src;
    } kih_drive_state_t;

    typedef struct packed {
        logic shortcut;
        logic run;
        logic stop;
        logic [2:0] func;
        logic up;
        logic down;
        logic left;
        logic right;
    } kih_keys_t;

    typedef struct packed {
        logic run_req;
        logic stop_req;
        logic fault_reset;
        logic jog;
        logic dir_toggle;
        logic clear_updn;
        logic coast_stop;
        logic cmd_step;
    } kih_cmds_t;

    typedef struct packed {
        logic [2:0] func;
        logic up;
        logic down;
        logic left;
        logic right;
    } kih_nav_t;

endpackage

// *** logic/kih_blink.sv ***
// Blink generator: square wave with a fixed half period
`timescale 1ns/1ps
module kih_blink
    import kih_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Blink phase
    output logic phase_o
);

    logic [BLINK_W-1:0] cnt_q;
    logic phase_q;

    // Shared period keeps both lamps in step [R14]
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cnt_q <= '0;
            phase_q <= 1'b0;
        end else if (cnt_q == BLINK_W'(HALF_CYC - 1)) begin
            cnt_q <= '0;
            phase_q <= ~phase_q;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign phase_o = phase_q;

endmodule

// *** logic/kih_keypad.sv ***
// Keypad front panel: lamps, key decode, display sizing, registers
`timescale 1ns/1ps
// What this block does
// R1: Run lamp off stopped, on running, blinking during autotune.
// R2: Fault lamp on in fault, off normal, blinking in pre-alarm.
// R3: Shortcut action chosen by code; 0 none, 1 jog, 3..6 actions, 2,7 reserved.
// R4: Restoring defaults sets the shortcut code back to jog.
// R5: Shortcut lamp follows action; jog normally-open, others normally-closed.
// R6: Run key starts only when command source is keypad.
// R7: Stop key halts running or autotune, limited by stop-key scope.
// R8: In fault, stop key issues fault reset from any command source.
// R9: Display is 240 by 160, showing three monitors or six sub-menu items.
// R10: Function keys mean what the current menu says; footer shows it.
// R11: Up and down shift items or change digits per interface.
// R12: Left and right move cursor; left exits menu, right enters next.
// R13: Fault code stays displayed until the fault is removed.
// R14: Both lamps blink with one fixed configurable period.
module kih_keypad
    import kih_pkg::*;
#(
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Drive state from controller (over the cable)
    input wire kih_drive_state_t drive_i,
    // Raw keys from panel
    input wire kih_keys_t keys_i,
    // Commands to drive
    output kih_cmds_t cmds_o,
    // Navigation events to menu logic
    output kih_nav_t nav_o,
    // Lamps
    output logic run_lamp_o,
    output logic fault_lamp_o,
    output logic shortcut_lamp_o,
    // Display content
    output logic fault_hold_o,
    output logic [2:0] disp_items_o,
    // Interrupt
    output logic irq_o
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    kih_drive_state_t drv_m_q, drv_q;
    kih_keys_t key_m_q, key_q, key_prev_q;
    kih_keys_t key_edge;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            drv_m_q <= '0;
            drv_q <= '0;
            key_m_q <= '0;
            key_q <= '0;
            key_prev_q <= '0;
        end else begin
            drv_m_q <= drive_i;
            drv_q <= drv_m_q;
            key_m_q <= keys_i;
            key_q <= key_m_q;
            key_prev_q <= key_q;
        end
    end

    // Press events only; a held key acts once, except jog, which follows key_q.shortcut
    assign key_edge = key_q & ~key_prev_q;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    kih_shortcut_t shortcut_q;
    logic stop_scope_q;
    logic submenu_q;
    logic [7:0] footer_q;
    logic [EV_W-1:0] irq_stat_q, irq_mask_q;
    logic [EV_W-1:0] events;
    logic is_fault;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            shortcut_q <= kih_shortcut_t'(SHORTCUT_RESET);
            stop_scope_q <= STOPSCOPE_RESET;
        end else if (reg_wr_i && hit(reg_addr_i, ADDR_CTRL)) begin
            if (reg_wdata_i[CTRL_DEFAULTS_BIT]) begin
                shortcut_q <= kih_shortcut_t'(SHORTCUT_RESET); // [R4]
                stop_scope_q <= STOPSCOPE_RESET;
            end else begin
                shortcut_q <= kih_shortcut_t'(reg_wdata_i[CTRL_SHORTCUT_LSB +: 3]); // [R3]
                stop_scope_q <= reg_wdata_i[CTRL_STOPSCOPE_BIT];
            end
        end
    end

    // Menu layout and footer labels come from menu software [R10]
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            submenu_q <= 1'b0;
            footer_q <= '0;
        end else if (reg_wr_i && hit(reg_addr_i, ADDR_MENU)) begin
            submenu_q <= reg_wdata_i[8];
            footer_q <= reg_wdata_i[7:0];
        end
    end

    // ------------------------------------------------------------
    // Key decode
    // ------------------------------------------------------------
    kih_cmds_t cmds_d, cmds_q;
    logic keypad_src;
    logic active;

    assign keypad_src = drv_q.cmd_src == CMD_KEYPAD;
    assign active = drv_q.running | drv_q.autotune;
    assign is_fault = drv_q.fault;

    always_comb begin
        cmds_d = '0;
        cmds_d.run_req = key_edge.run && keypad_src && !is_fault; // [R6]
        // Scope 0: keypad source only; scope 1: any source [R7]
        cmds_d.stop_req = key_edge.stop && active && !is_fault && (keypad_src || stop_scope_q);
        cmds_d.fault_reset = key_edge.stop && is_fault; // [R8]
        cmds_d.jog = key_q.shortcut && shortcut_q == SC_JOG; // [R3]
        if (key_edge.shortcut) begin
            unique case (shortcut_q) // [R3]
                SC_JOG: cmds_d.jog = 1'b1;
                SC_DIR_TOGGLE: cmds_d.dir_toggle = 1'b1;
                SC_CLEAR_UPDN: cmds_d.clear_updn = 1'b1;
                SC_COAST: cmds_d.coast_stop = 1'b1;
                SC_CMD_STEP: cmds_d.cmd_step = 1'b1;
                SC_NONE, SC_RSVD2, SC_RSVD7: cmds_d = cmds_d;
            endcase
        end
    end

    // Jog is a level: held while the key is held
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cmds_q <= '0;
        end else begin
            cmds_q <= cmds_d;
        end
    end

    // Navigation pulses, meaning resolved by the menu logic [R11] [R12]
    kih_nav_t nav_q;
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            nav_q <= '0;
        end else begin
            nav_q.func <= key_edge.func; // [R10]
            nav_q.up <= key_edge.up; // [R11]
            nav_q.down <= key_edge.down; // [R11]
            nav_q.left <= key_edge.left; // [R12]
            nav_q.right <= key_edge.right; // [R12]
        end
    end

    // ------------------------------------------------------------
    // Lamps
    // ------------------------------------------------------------
    logic blink;
    logic run_lamp_q, fault_lamp_q, sc_lamp_q, sc_latch_q;

    kih_blink #(
        .HALF_CYC(BLINK_HALF)
    ) u_blink (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .phase_o(blink)
    );

    // Toggle state for the normally-closed actions
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            sc_latch_q <= 1'b0;
        end else if (reg_wr_i && hit(reg_addr_i, ADDR_CTRL)) begin
            sc_latch_q <= 1'b0;
        end else if (key_edge.shortcut) begin
            sc_latch_q <= ~sc_latch_q;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            run_lamp_q <= 1'b0;
            fault_lamp_q <= 1'b0;
            sc_lamp_q <= 1'b0;
        end else begin
            run_lamp_q <= drv_q.autotune ? blink : drv_q.running; // [R1] [R14]
            fault_lamp_q <= drv_q.fault ? 1'b1 : (drv_q.pre_alarm & blink); // [R2] [R14]
            unique case (shortcut_q) // [R5]
                SC_JOG: sc_lamp_q <= key_q.shortcut;
                SC_DIR_TOGGLE, SC_CLEAR_UPDN, SC_COAST, SC_CMD_STEP: sc_lamp_q <= ~sc_latch_q;
                SC_NONE, SC_RSVD2, SC_RSVD7: sc_lamp_q <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Display content
    // ------------------------------------------------------------
    logic fault_hold_q;
    logic [2:0] items_q;

    // Hold the fault screen until the fault itself clears [R13]
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            fault_hold_q <= 1'b0;
        end else begin
            fault_hold_q <= drv_q.fault;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            items_q <= MONITOR_ITEMS;
        end else begin
            items_q <= submenu_q ? SUBMENU_ITEMS : MONITOR_ITEMS; // [R9]
        end
    end

    // ------------------------------------------------------------
    // Interrupts and read port
    // ------------------------------------------------------------
    logic irq_q;
    logic stat_rd;
    logic [31:0] rdata_q;

    assign events = {|key_edge.func, key_edge.up | key_edge.down | key_edge.left | key_edge.right,
                     key_edge.shortcut, cmds_d.fault_reset, cmds_d.stop_req, cmds_d.run_req};
    assign stat_rd = reg_rd_i && hit(reg_addr_i, ADDR_IRQ_STAT);

    // New event wins over the read clear
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | events;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            irq_mask_q <= '0;
        end else if (reg_wr_i && hit(reg_addr_i, ADDR_IRQ_MASK)) begin
            irq_mask_q <= reg_wdata_i[EV_W-1:0];
        end
    end

    // One cycle behind the status bit; a mask change also reaches irq one cycle later
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= '0;
        end else if (reg_rd_i) begin
            rdata_q <= '0;
            unique case (reg_addr_i)
                ADDR_CTRL: begin
                    rdata_q[CTRL_SHORTCUT_LSB +: 3] <= shortcut_q;
                    rdata_q[CTRL_STOPSCOPE_BIT] <= stop_scope_q;
                end
                ADDR_STATUS: rdata_q[7:0] <= {run_lamp_q, fault_lamp_q, sc_lamp_q,
                                              fault_hold_q, drv_q.running, drv_q.autotune,
                                              drv_q.fault, drv_q.pre_alarm};
                ADDR_IRQ_STAT: rdata_q[EV_W-1:0] <= irq_stat_q;
                ADDR_IRQ_MASK: rdata_q[EV_W-1:0] <= irq_mask_q;
                ADDR_MENU: rdata_q[8:0] <= {submenu_q, footer_q};
                ADDR_DISPLAY: rdata_q[18:0] <= {items_q, DISP_ROWS, DISP_COLS};
                default: rdata_q <= '0;
            endcase
        end
    end

    assign reg_rdata_o = rdata_q;
    assign cmds_o = cmds_q;
    assign nav_o = nav_q;
    assign run_lamp_o = run_lamp_q;
    assign fault_lamp_o = fault_lamp_q;
    assign shortcut_lamp_o = sc_lamp_q;
    assign fault_hold_o = fault_hold_q;
    assign disp_items_o = items_q;
    assign irq_o = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_fault_stop;
        key_edge.stop && drv_q.fault;
    endsequence

    AST_RUN_KEYPAD_ONLY: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R6]
        cmds_q.run_req |-> $past(keypad_src)) else $error("run without keypad source");
    AST_FAULT_RESET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R8]
        s_fault_stop |=> cmds_q.fault_reset && !cmds_q.stop_req) else $error("no fault reset");
    AST_STOP_SCOPE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R7]
        cmds_q.stop_req |-> $past(active) && ($past(keypad_src) || $past(stop_scope_q)))
        else $error("stop outside scope");
    AST_RUN_LAMP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R1]
        !drv_q.running && !drv_q.autotune ##1 1'b1 |-> !run_lamp_q) else $error("run lamp lit");
    AST_FAULT_LAMP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R2]
        drv_q.fault |=> fault_lamp_q) else $error("fault lamp dark");
    AST_DEFAULTS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R4]
        reg_wr_i && hit(reg_addr_i, ADDR_CTRL) && reg_wdata_i[CTRL_DEFAULTS_BIT]
        |=> shortcut_q == SC_JOG) else $error("defaults not restored");
    AST_SC_NONE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R3]
        key_edge.shortcut && shortcut_q == SC_NONE |=> !cmds_q.dir_toggle && !cmds_q.coast_stop)
        else $error("no-function shortcut acted");
    AST_JOG_LAMP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R5]
        shortcut_q == SC_JOG && $stable(shortcut_q) && !key_q.shortcut |=> !sc_lamp_q)
        else $error("jog lamp not normally open");
    AST_FAULT_HOLD: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R13]
        drv_q.fault [*2] |-> fault_hold_q) else $error("fault screen dropped");
    AST_ITEMS: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i) // [R9]
        submenu_q [*2] |-> disp_items_o == SUBMENU_ITEMS) else $error("wrong item count");

endmodule

// *** dv/kih_drive_model.sv ***
// Drive controller model facing the keypad across the cable
`timescale 1ns/1ps
module kih_drive_model
    import kih_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    // Conditions set by the bench
    input wire logic tune_i,
    input wire logic fault_i,
    input wire logic pre_i,
    input wire logic [1:0] src_i,
    // Keypad side
    input wire kih_cmds_t cmds_i,
    output kih_drive_state_t drive_o
);
    logic running_q;

    // ------------------------------------------------------------
    // Run state
    // ------------------------------------------------------------
    // A fault drops the run state, as a real drive trips its output
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i || fault_i) begin
            running_q <= 1'h0;
        end else if (cmds_i.stop_req || cmds_i.coast_stop) begin
            running_q <= 1'h0;
        end else if (cmds_i.run_req) begin
            running_q <= 1'h1;
        end
    end

    assign drive_o = {running_q, tune_i, fault_i, pre_i, src_i};
endmodule

// *** dv/tb_keypad_indicator_key_handler.sv ***
// Self-checking bench for the keypad panel logic
`timescale 1ns/1ps
module tb_keypad_indicator_key_handler;
    import kih_pkg::*;

    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    // Short blink so a full period fits in a few cycles
    localparam int HALF = 4;
    localparam logic [9:0] K_SC = 10'h200;
    localparam logic [9:0] K_RUN = 10'h100;
    localparam logic [9:0] K_STOP = 10'h080;
    logic ref_clk_i = 1'h0;
    logic reset_n_i = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [31:0] rdata;
    kih_keys_t keys = '0;
    kih_drive_state_t drive;
    kih_cmds_t cmds;
    kih_nav_t nav;
    logic run_lamp, fault_lamp, sc_lamp, hold, irq, sc_hold;
    logic [2:0] items;
    logic tune = 1'h0;
    logic flt = 1'h0;
    logic pre = 1'h0;
    logic [1:0] src = 2'h0;
    logic [15:0] lfsr = 16'h8E44;
    int n_errors = 0;
    int n_checks = 0;
    int m_run = 0;
    int m_scope = 0;
    int m_code = 1;

    initial forever #2 ref_clk_i = ~ref_clk_i;

    kih_keypad #(.BLINK_HALF(HALF)) i_dut (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .drive_i(drive), .keys_i(keys), .cmds_o(cmds), .nav_o(nav),
        .run_lamp_o(run_lamp), .fault_lamp_o(fault_lamp), .shortcut_lamp_o(sc_lamp),
        .fault_hold_o(hold), .disp_items_o(items), .irq_o(irq));

    kih_drive_model i_drive (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .tune_i(tune), .fault_i(flt),
        .pre_i(pre), .src_i(src), .cmds_i(cmds), .drive_o(drive));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge ref_clk_i);
        wr <= 1'h0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        addr <= a;
        rd <= 1'h1;
        @(posedge ref_clk_i);
        rd <= 1'h0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic state(input logic [1:0] s, input logic t, input logic f, input logic p);
        @(posedge ref_clk_i);
        src <= s;
        tune <= t;
        flt <= f;
        pre <= p;
        cyc(5);
    endtask

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic kih_cmds_t expect_cmd(input logic [9:0] k);
        kih_cmds_t e;
        e = '0;
        e.run_req = k[8] && src == 2'h0 && !flt;
        e.fault_reset = k[7] && flt;
        e.stop_req = k[7] && !flt && (m_run != 0 || tune) && (m_scope != 0 || src == 2'h0);
        e.jog = k[9] && m_code == 1;
        e.dir_toggle = k[9] && m_code == 3;
        e.clear_updn = k[9] && m_code == 4;
        e.coast_stop = k[9] && m_code == 5;
        e.cmd_step = k[9] && m_code == 6;
        return e;
    endfunction

    // Pulses are ORed over a window; the single pulse must land on the third sample
    task automatic press(input logic [9:0] k);
        kih_cmds_t ec;
        kih_cmds_t acc;
        kih_nav_t nacc;
        int pulses;
        int at;
        int n;
        ec = expect_cmd(k);
        acc = '0;
        nacc = '0;
        pulses = 0;
        at = 0;
        n = 0;
        @(posedge ref_clk_i);
        keys <= kih_keys_t'(k);
        repeat (6) begin
            @(posedge ref_clk_i);
            #1;
            n++;
            acc = acc | cmds;
            nacc = nacc | nav;
            if ((cmds & 8'hEF) != 8'h00 || nav != 7'h00) begin
                pulses++;
                at = n;
            end
        end
        sc_hold = sc_lamp;
        chk(acc, ec);
        chk(nacc, k[6:0]);
        chk(pulses, ((ec & 8'hEF) != 8'h00 || k[6:0] != 7'h00) ? 1 : 0);
        chk(at, ((ec & 8'hEF) != 8'h00 || k[6:0] != 7'h00) ? 3 : 0);
        if (ec.run_req) m_run = 1;
        if (ec.stop_req || ec.coast_stop) m_run = 0;
        @(posedge ref_clk_i);
        keys <= '0;
        cyc(5);
    endtask

    task automatic blink(input logic fault_side);
        int hi;
        hi = 0;
        repeat (16) begin
            @(posedge ref_clk_i);
            #1;
            hi += fault_side ? fault_lamp : run_lamp;
        end
        chk(hi, 8);
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #100000;
        n_errors++;
        $display("mismatch at %0t: run timeout", $time);
        conclude();
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        reset_n_i <= 1'h1;
        rd_reg(ADDR_CTRL, 32'h1);
        chk(items, 3'h3);
        rd_reg(ADDR_DISPLAY, 32'h0003A0F0);
        rd_reg(8'h1C, 32'h0);
        wr_reg(ADDR_CTRL, 32'h15);
        rd_reg(ADDR_CTRL, 32'h15);
        wr_reg(ADDR_CTRL, 32'h100);
        rd_reg(ADDR_CTRL, 32'h1);
        wr_reg(ADDR_IRQ_MASK, 32'h3F);
        rd_reg(ADDR_IRQ_STAT, 32'h0);
        for (int i = 0; i < 7; i++) begin
            press(10'h1 << i);
            chk(irq, 1'h1);
            rd_reg(ADDR_IRQ_STAT, (i > 3) ? 32'h20 : 32'h10);
            cyc(2);
            chk(irq, 1'h0);
        end
        wr_reg(ADDR_IRQ_MASK, 32'h0);
        press(10'h008);
        chk(irq, 1'h0);
        rd_reg(ADDR_IRQ_STAT, 32'h10);
        // Run only from the keypad source, stop limited by scope
        state(2'h1, 1'h0, 1'h0, 1'h0);
        press(K_RUN);
        state(2'h0, 1'h0, 1'h0, 1'h0);
        press(K_RUN);
        chk(run_lamp, 1'h1);
        rd_reg(ADDR_STATUS, 32'h88);
        state(2'h1, 1'h0, 1'h0, 1'h0);
        press(K_STOP);
        wr_reg(ADDR_CTRL, 32'h11);
        m_scope = 1;
        press(K_STOP);
        chk(run_lamp, 1'h0);
        state(2'h0, 1'h1, 1'h0, 1'h0);
        blink(1'h0);
        press(K_STOP);
        state(2'h0, 1'h0, 1'h0, 1'h1);
        blink(1'h1);
        wr_reg(ADDR_CTRL, 32'h1);
        m_scope = 0;
        state(2'h0, 1'h0, 1'h1, 1'h0);
        chk(fault_lamp, 1'h1);
        chk(hold, 1'h1);
        rd_reg(ADDR_STATUS, 32'h52);
        press(K_RUN);
        state(2'h2, 1'h0, 1'h1, 1'h0);
        press(K_STOP);
        chk(hold, 1'h1);
        state(2'h2, 1'h0, 1'h0, 1'h0);
        chk(hold, 1'h0);
        chk(fault_lamp, 1'h0);
        state(2'h0, 1'h0, 1'h0, 1'h0);
        for (int c = 0; c < 8; c++) begin
            wr_reg(ADDR_CTRL, 32'(c));
            m_code = c;
            cyc(4);
            chk(sc_lamp, (c > 2 && c < 7) ? 1'h1 : 1'h0);
            press(K_SC);
            chk(sc_hold, (c == 1) ? 1'h1 : 1'h0);
            chk(sc_lamp, 1'h0);
        end
        for (int i = 0; i < 4; i++) begin
            lfsr = lfsr_next(lfsr);
            wr_reg(ADDR_MENU, {23'h0, i[0], lfsr[7:0]});
            rd_reg(ADDR_MENU, {23'h0, i[0], lfsr[7:0]});
            cyc(2);
            chk(items, i[0] ? 3'h6 : 3'h3);
        end
        conclude();
    end
endmodule
